// ===== core/epi_consts.svh
// Purpose: constants for the external pin interrupt unit
// Assumes: classic wishbone register bus, 32-bit data
// Notes: byte offsets of word registers
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH
`define EPI_OFF_SENSE_LO 8'h00
`define EPI_OFF_SENSE_HI 8'h04
`define EPI_OFF_MASK 8'h08
`define EPI_OFF_FLAGS 8'h0c
`define EPI_OFF_CTRL 8'h10
`define EPI_OFF_IRQ_STAT 8'h14
`define EPI_OFF_IRQ_MASK 8'h18
`define EPI_OFF_PINS 8'h1c
`define EPI_CTRL_GIE 0
`define EPI_CTRL_SLEEP 1
`define EPI_CTRL_IDLE 2
`define EPI_IST_WAKE 0
`define EPI_IST_REQ 1
`define EPI_SENSE_LOW 2'h0
`define EPI_SENSE_ANY 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3
`define EPI_WDT_PERIOD_NS 1000
`define EPI_CLK_PERIOD_NS 40
`define EPI_WDT_CYCLES (`EPI_WDT_PERIOD_NS / `EPI_CLK_PERIOD_NS)
`define EPI_STARTUP_CYCLES 64
`endif

// ===== core/epi_pkg.sv
// Purpose: types for the external pin interrupt unit
// Assumes: nothing
// Notes: wake sequencer states
package epi_pkg;
  typedef enum logic [3:0] {
    EPI_RUN = 4'h1,
    EPI_SLEEP = 4'h2,
    EPI_QUAL = 4'h4,
    EPI_START = 4'h8
  } epi_wake_t;
endpackage

// ===== core/epi_unit.sv
// Purpose: eight external request pins to per-pin processor requests
// Assumes: synchronous inputs, classic wishbone slave, 25 MHz clk_i
// Notes: the watchdog sample tick is a divided clk_i
`timescale 1ns/1ps
`include "epi_consts.svh"

// Summary of operation
// - eight independent request inputs, seven down zero
// - pins detected even when driven as outputs
// - low group and high group sense registers
// - level mode requests while pin low
// - high group edges need running io clock
// - low level wakes from every sleep mode
// - io clock stops outside run except in idle
// - wake pin level sampled twice, slow tick
// - wake on two samples of held level
// - level lost during startup: wake, no request
// - sense codes: low, change, fall, rise
// - low group edges ungated, high gated by io clock
// - request needs mask bit and global enable
// - edge sets flag; ack or one clears
module epi_unit #(
  parameter int NPINS = 8,
  parameter int STARTUP_CYCLES = `EPI_STARTUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] external_request_pins_i,
  input wire logic [7:0] vector_ack_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] core_request_o,
  output logic io_clk_run_o,
  output logic wake_o,
  output logic irq_o
);
  // ==========================================================
  // registers
  logic [7:0] low_group_sense_control_q;
  logic [7:0] high_group_sense_control_q;
  logic [7:0] external_request_mask_q;
  logic [7:0] external_request_flags_q;
  logic [2:0] ctrl_q;
  logic [1:0] ist_q;
  logic [1:0] imask_q;
  logic [7:0] pin_prev_q;
  logic [7:0] lvl_ok_q;
  logic [15:0] sense_all;
  logic [7:0] edge_hit;
  logic [7:0] level_act;
  logic [7:0] req_d;
  logic wr_stb;
  logic rd_stb;
  logic wake_ev;
  epi_pkg::epi_wake_t wst_q;
  logic [7:0] wdiv_q;
  logic [1:0] samp_q;
  logic [15:0] sut_q;
  logic any_low;

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign sense_all = {high_group_sense_control_q, low_group_sense_control_q};
  assign any_low = |(level_act & external_request_mask_q);

  // ==========================================================
  // edge and level detection
  // pins read regardless of direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_q <= 8'hff;
    end else begin
      pin_prev_q <= external_request_pins_i;
    end
  end

  always_comb begin
    edge_hit = 8'h00;
    level_act = 8'h00;
    for (int i = 0; i < NPINS; i++) begin
      unique case (sense_all[2*i +: 2])
        `EPI_SENSE_LOW: level_act[i] = ~external_request_pins_i[i];
        `EPI_SENSE_ANY: edge_hit[i] = pin_prev_q[i] ^ external_request_pins_i[i];
        `EPI_SENSE_FALL: edge_hit[i] = pin_prev_q[i] & ~external_request_pins_i[i];
        `EPI_SENSE_RISE: edge_hit[i] = ~pin_prev_q[i] & external_request_pins_i[i];
      endcase
      // high group edges gated by io clock
      if (i >= 4 && !io_clk_run_o) begin
        edge_hit[i] = 1'b0;
      end
    end
  end

  // ==========================================================
  // request flags
  // set wins over clear; level mode reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_request_flags_q <= 8'h00;
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (sense_all[2*i +: 2] == `EPI_SENSE_LOW) begin
          external_request_flags_q[i] <= 1'b0;
        end else if (edge_hit[i]) begin
          external_request_flags_q[i] <= 1'b1;
        end else if (vector_ack_i[i] || (wr_stb && wb_adr_i == `EPI_OFF_FLAGS && wb_dat_i[i])) begin
          external_request_flags_q[i] <= 1'b0;
        end
      end
    end
  end

  // level request only once awake and qualified
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      lvl_ok_q[i] = level_act[i] & (wst_q == epi_pkg::EPI_RUN);
    end
  end

  // mask and global enable gate requests
  assign req_d = (external_request_flags_q | lvl_ok_q) & external_request_mask_q & {8{ctrl_q[`EPI_CTRL_GIE]}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_request_o <= 8'h00;
    end else begin
      core_request_o <= req_d;
    end
  end

  // ==========================================================
  // sleep and wake sequencer
  // io clock only in run or idle sleep
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_clk_run_o <= 1'b1;
    end else begin
      io_clk_run_o <= (wst_q == epi_pkg::EPI_RUN) | ctrl_q[`EPI_CTRL_IDLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wst_q == epi_pkg::EPI_RUN || wdiv_q == 8'(`EPI_WDT_CYCLES - 1)) begin
      wdiv_q <= 8'h00;
    end else begin
      wdiv_q <= wdiv_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wst_q <= epi_pkg::EPI_RUN;
      samp_q <= 2'h0;
      sut_q <= 16'h0000;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      unique case (wst_q)
        epi_pkg::EPI_RUN: begin
          if (ctrl_q[`EPI_CTRL_SLEEP]) begin
            wst_q <= epi_pkg::EPI_SLEEP;
          end
        end
        epi_pkg::EPI_SLEEP: begin
          samp_q <= 2'h0;
          if (any_low) begin
            wst_q <= epi_pkg::EPI_QUAL;
          end
        end
        epi_pkg::EPI_QUAL: begin
          if (wdiv_q == 8'(`EPI_WDT_CYCLES - 1)) begin
            if (!any_low) begin
              wst_q <= epi_pkg::EPI_SLEEP;
            end else if (samp_q == 2'h1) begin
              wst_q <= epi_pkg::EPI_START;
              sut_q <= 16'h0000;
            end else begin
              samp_q <= samp_q + 2'h1;
            end
          end
        end
        epi_pkg::EPI_START: begin
          sut_q <= sut_q + 16'h0001;
          if (sut_q == 16'(STARTUP_CYCLES - 1)) begin
            wst_q <= epi_pkg::EPI_RUN;
            wake_o <= 1'b1;
          end
        end
      endcase
    end
  end

  assign wake_ev = wake_o;

  // ==========================================================
  // register bus and interrupt status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_group_sense_control_q <= 8'h00;
      high_group_sense_control_q <= 8'h00;
      external_request_mask_q <= 8'h00;
      ctrl_q <= 3'h0;
      imask_q <= 2'h0;
    end else begin
      if (wst_q == epi_pkg::EPI_START && sut_q == 16'(STARTUP_CYCLES - 1)) begin
        ctrl_q[`EPI_CTRL_SLEEP] <= 1'b0;
      end
      if (wr_stb) begin
        unique case (wb_adr_i)
          `EPI_OFF_SENSE_LO: low_group_sense_control_q <= wb_dat_i[7:0];
          `EPI_OFF_SENSE_HI: high_group_sense_control_q <= wb_dat_i[7:0];
          `EPI_OFF_MASK: external_request_mask_q <= wb_dat_i[7:0];
          `EPI_OFF_CTRL: ctrl_q <= wb_dat_i[2:0];
          `EPI_OFF_IRQ_MASK: imask_q <= wb_dat_i[1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == `EPI_IST_WAKE && wake_ev) || (b == `EPI_IST_REQ && |(req_d & ~core_request_o))) begin
          ist_q[b] <= 1'b1;
        end else if (wr_stb && wb_adr_i == `EPI_OFF_IRQ_STAT && wb_dat_i[b]) begin
          ist_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ist_q & imask_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= rd_stb;
      wb_dat_o <= 32'h00000000;
      if (rd_stb && !wb_we_i) begin
        unique case (wb_adr_i)
          `EPI_OFF_SENSE_LO: wb_dat_o <= {24'h000000, low_group_sense_control_q};
          `EPI_OFF_SENSE_HI: wb_dat_o <= {24'h000000, high_group_sense_control_q};
          `EPI_OFF_MASK: wb_dat_o <= {24'h000000, external_request_mask_q};
          `EPI_OFF_FLAGS: wb_dat_o <= {24'h000000, external_request_flags_q};
          `EPI_OFF_CTRL: wb_dat_o <= {29'h00000000, ctrl_q};
          `EPI_OFF_IRQ_STAT: wb_dat_o <= {30'h00000000, ist_q};
          `EPI_OFF_IRQ_MASK: wb_dat_o <= {30'h00000000, imask_q};
          `EPI_OFF_PINS: wb_dat_o <= {24'h000000, external_request_pins_i};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  // no request without global enable
  gie_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ctrl_q[`EPI_CTRL_GIE]) |-> core_request_o == 8'h00)
    else $error("request without global enable");
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_hit[0] |=> external_request_flags_q[0])
    else $error("edge did not set flag");
  // high edges ignored with io clock stopped
  io_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !io_clk_run_o |=> (external_request_flags_q[7:4] & ~$past(external_request_flags_q[7:4])) == 4'h0)
    else $error("high edge with io clock stopped");
  level_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_group_sense_control_q[1:0] == 2'h0 && !external_request_pins_i[0] && external_request_mask_q[0]
     && ctrl_q[0] && wst_q == epi_pkg::EPI_RUN) |=> core_request_o[0])
    else $error("level request missing");
  // io clock stopped in deep sleep
  io_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wst_q == epi_pkg::EPI_SLEEP && !ctrl_q[`EPI_CTRL_IDLE]) |=> !io_clk_run_o)
    else $error("io clock runs in deep sleep");
  wake_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wst_q == epi_pkg::EPI_START) |-> ##[1:300] wake_o)
    else $error("startup did not end");
  qual_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wst_q == epi_pkg::EPI_START) |-> $past(wst_q, 25) == epi_pkg::EPI_QUAL)
    else $error("qualification too short");
  // ack clears flag without new edge
  ack_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (vector_ack_i[4] && !edge_hit[4]) |=> !external_request_flags_q[4])
    else $error("ack did not clear flag");
  rise_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_group_sense_control_q[1:0] == `EPI_SENSE_RISE && !pin_prev_q[0] && external_request_pins_i[0])
    |=> external_request_flags_q[0])
    else $error("rise code missed an edge");
  fall_sense_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (high_group_sense_control_q[1:0] == `EPI_SENSE_FALL && io_clk_run_o && pin_prev_q[4]
     && !external_request_pins_i[4]) |=> external_request_flags_q[4])
    else $error("fall code missed an edge");
  level_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    low_group_sense_control_q[1:0] == `EPI_SENSE_LOW |=> !external_request_flags_q[0])
    else $error("flag set in level mode");
  mask_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(external_request_mask_q[0]) |-> !core_request_o[0])
    else $error("request on masked pin");
  sleep_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wst_q == epi_pkg::EPI_SLEEP && any_low) |=> wst_q == epi_pkg::EPI_QUAL)
    else $error("low level did not start wake");
  idle_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q[`EPI_CTRL_IDLE] |=> io_clk_run_o)
    else $error("io clock stopped in idle");
  start_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wst_q == epi_pkg::EPI_START && sut_q == 16'(STARTUP_CYCLES - 1)) |=> (wake_o && wst_q == epi_pkg::EPI_RUN))
    else $error("startup end did not wake");
  asleep_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(wst_q) != epi_pkg::EPI_RUN && $past(external_request_flags_q) == 8'h00) |-> core_request_o == 8'h00)
    else $error("level request before wake");
endmodule

// ===== dv/epi_pin_drv.sv
// Purpose: far-side model, pin drivers and core acknowledge
// Assumes: commands change just after clk_i
// Notes: ack only while ack_en_i is high
`timescale 1ns/1ps
module epi_pin_drv (
  input wire logic clk_i,
  input wire logic [7:0] pin_cmd_i,
  input wire logic ack_en_i,
  input wire logic [7:0] core_request_i,
  output logic [7:0] pins_o,
  output logic [7:0] ack_o
);
  // ==========
  // pin and acknowledge drive
  // holds commanded level
  always @(posedge clk_i) begin
    pins_o <= pin_cmd_i;
  end
  always @(posedge clk_i) begin
    ack_o <= ack_en_i ? (core_request_i & ~ack_o) : 8'h00;
  end
endmodule

// ===== dv/external_pin_interrupt_unit_tb.sv
// Purpose: self-checking bench for epi_unit
// Assumes: classic wishbone, 40 ns clock
// Notes: read results checked from a queue
`timescale 1ns/1ps
`include "epi_consts.svh"
module external_pin_interrupt_unit_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, ack_en = 0, irq, wake, ioclk;
  logic [7:0] adr = 0, pcmd = 8'hff, pins, vack, creq, p, v;
  logic [31:0] wdat = 0, rdat, st = 32'h1610;
  logic [31:0] exp_q[$];
  int fail_count = 0, n_compared = 0;
  epi_unit #(.STARTUP_CYCLES(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .external_request_pins_i(pins),
    .vector_ack_i(vack), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .core_request_o(creq), .io_clk_run_o(ioclk),
    .wake_o(wake), .irq_o(irq));
  epi_pin_drv drv (.clk_i(clk_i), .pin_cmd_i(pcmd), .ack_en_i(ack_en), .core_request_i(creq),
    .pins_o(pins), .ack_o(vack));
  // ==========
  // clock, checks, bus tasks
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_req(input logic [7:0] e);
    cmp({24'h0, e}, {24'h0, creq});
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) cmp(exp_q.pop_front(), rdat);
  end
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    adr <= a;
    we <= w;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) cmp(32'h1, 32'h0);
    cyc <= 0;
    stb <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(a, 0, 0);
  endtask
  task automatic pin(input logic [7:0] x);
    @(posedge clk_i);
    pcmd <= x;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    cmp(32'h1, {31'h0, wake});
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    fail_count++;
    report_and_stop();
  end
  // ==========
  // scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rd(`EPI_OFF_SENSE_LO, 0);
    rd(`EPI_OFF_SENSE_HI, 0);
    rd(`EPI_OFF_MASK, 0);
    wr(8'h40, 32'hff);
    rd(8'h40, 0);
    $display("test reset done");
    wr(`EPI_OFF_MASK, 32'hff);
    wr(`EPI_OFF_CTRL, 32'h1);
    for (int c = 1; c < 4; c++) begin
      wr(`EPI_OFF_SENSE_LO, {24'h0, {4{c[1:0]}}});
      wr(`EPI_OFF_SENSE_HI, {24'h0, {4{c[1:0]}}});
      wr(`EPI_OFF_FLAGS, 32'hff);
      pin(8'h00);
      rd(`EPI_OFF_FLAGS, (c == 3) ? 0 : 32'hff);
      pin(8'hff);
      rd(`EPI_OFF_FLAGS, 32'hff);
      cmp_req(8'hff);
    end
    wr(`EPI_OFF_MASK, 32'h0f);
    cmp_req(8'h0f);
    wr(`EPI_OFF_CTRL, 32'h0);
    cmp_req(8'h00);
    wr(`EPI_OFF_CTRL, 32'h1);
    wr(`EPI_OFF_FLAGS, 32'h0f);
    rd(`EPI_OFF_FLAGS, 32'hf0);
    ack_en <= 1;
    wr(`EPI_OFF_MASK, 32'hff);
    rd(`EPI_OFF_FLAGS, 0);
    ack_en <= 0;
    $display("test edge modes done");
    wr(`EPI_OFF_SENSE_LO, 32'h55);
    wr(`EPI_OFF_SENSE_HI, 32'h55);
    p = 8'hff;
    for (int i = 0; i < 4; i++) begin
      st = xs(st);
      v = st[7:0];
      wr(`EPI_OFF_FLAGS, 32'hff);
      pin(v);
      rd(`EPI_OFF_FLAGS, {24'h0, p ^ v});
      wr(`EPI_OFF_MASK, {24'h0, st[15:8]});
      cmp_req((p ^ v) & st[15:8]);
      p = v;
    end
    $display("test random change done");
    wr(`EPI_OFF_SENSE_LO, 0);
    wr(`EPI_OFF_SENSE_HI, 0);
    wr(`EPI_OFF_MASK, 32'hff);
    pin(8'h00);
    cmp_req(8'hff);
    rd(`EPI_OFF_FLAGS, 0);
    pin(8'hff);
    cmp_req(8'h00);
    $display("test level done");
    wr(`EPI_OFF_SENSE_HI, 32'hff);
    wr(`EPI_OFF_MASK, 32'h01);
    pin(8'h0f);
    wr(`EPI_OFF_FLAGS, 32'hff);
    wr(`EPI_OFF_IRQ_MASK, 32'h1);
    wr(`EPI_OFF_IRQ_STAT, 32'h3);
    wr(`EPI_OFF_CTRL, 32'h3);
    cmp(0, {31'h0, ioclk});
    pin(8'hfe);
    wait_wake();
    repeat (3) @(posedge clk_i);
    cmp_req(8'h01);
    cmp(1, {31'h0, ioclk});
    rd(`EPI_OFF_FLAGS, 0);
    cmp(1, {31'h0, irq});
    wr(`EPI_OFF_IRQ_STAT, 32'h3);
    cmp(0, {31'h0, irq});
    pin(8'hff);
    wr(`EPI_OFF_CTRL, 32'h3);
    pin(8'hfe);
    repeat (55) @(posedge clk_i);
    pin(8'hff);
    wait_wake();
    repeat (3) @(posedge clk_i);
    cmp_req(8'h00);
    $display("test sleep done");
    rd(`EPI_OFF_PINS, 32'hff);
    wr(`EPI_OFF_FLAGS, 32'hff);
    wr(`EPI_OFF_CTRL, 32'h7);
    cmp(1, {31'h0, ioclk});
    pin(8'h7f);
    pin(8'hff);
    rd(`EPI_OFF_FLAGS, 32'h80);
    pin(8'hfe);
    wait_wake();
    repeat (3) @(posedge clk_i);
    cmp_req(8'h01);
    pin(8'hff);
    $display("test idle done");
    report_and_stop();
  end
endmodule
